//--- mscod_pkg.sv
// Shared constants and carrier types for the Manchester serial codec
`default_nettype none

package mscod_pkg;

   // System clock doubles as the 2x reference: one cycle is one half bit
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned RX_GLITCH_NS    = 16;
   localparam int unsigned COL_GLITCH_NS   = 10;
   localparam int unsigned COL_HOLD_NS     = 80;
   localparam int unsigned ACQ_BIT_TIMES   = 6;
   localparam int unsigned IDLE_HOLD_NS    = 200;

   // Least times round up, never below one cycle
   function automatic int unsigned mscod_min_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned RX_FILT_CYC   = mscod_min_cyc(RX_GLITCH_NS);
   localparam int unsigned COL_FILT_CYC  = mscod_min_cyc(COL_GLITCH_NS);
   localparam int unsigned COL_HOLD_CYC  = mscod_min_cyc(COL_HOLD_NS);
   localparam int unsigned ACQ_CYC       = 2 * ACQ_BIT_TIMES;

   // Half-bit gap counter codes on the receive line
   localparam logic [1:0] RX_GAP_HALF = 2'h1;
   localparam logic [1:0] RX_GAP_EOP  = 2'h3;

   typedef struct packed {
      logic clk;
      logic data;
      logic carrier;
   } mscod_rx_s;

   typedef enum {
      TX_REST,
      TX_SEND,
      TX_HOLD,
      TX_IDLE_HIGH
   } mscod_tx_e;

endpackage : mscod_pkg

`default_nettype wire

//--- mscod_filt.sv
// Pin synchroniser with transient rejection for the line receivers
`default_nettype none

module mscod_filt #(
   parameter int unsigned STABLE_CYC = 1
) (
   input  wire logic i_sys_clk,
   input  wire logic i_rst_b,
   input  wire logic i_clk_en,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_edge
);
   localparam int unsigned CW = $clog2(STABLE_CYC + 1);

   logic          sync1;
   logic          sync2;
   logic [CW-1:0] cnt;
   wire           differ = (sync2 != o_level);
   // A new value must be seen on STABLE_CYC samples in a row
   wire           accept = differ && (cnt == CW'(STABLE_CYC - 1));

   if (STABLE_CYC < 1) begin : g_bad
      $error("mscod_filt: STABLE_CYC must be at least 1");
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         sync1   <= 1'b0;
         sync2   <= 1'b0;
         cnt     <= '0;
         o_level <= 1'b0;
         o_edge  <= 1'b0;
      end else if (i_clk_en) begin
         sync1   <= i_pin;
         sync2   <= sync1;
         cnt     <= (differ && !accept) ? cnt + CW'(1) : '0;
         o_level <= accept ? sync2 : o_level;
         o_edge  <= accept;
      end
   end

   AST_FILT_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_clk_en && differ && cnt != CW'(STABLE_CYC - 1)) |=> (o_level == $past(o_level)))
      else $error("filter passed a short transient");
   // Edge flag only with a level change
   AST_FILT_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      ($past(i_clk_en) && o_edge) |-> (o_level != $past(o_level)))
      else $error("edge flag without level change");

endmodule // mscod_filt

`default_nettype wire

//--- mscod_codec.sv
// Manchester serial codec: encoder, receive conditioning, decoder, collision flag
`default_nettype none

module mscod_codec
   import mscod_pkg::*;
#(
   parameter int unsigned IDLE_HOLD_T_NS = IDLE_HOLD_NS
) (
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst_b,
   input  wire logic  i_clk_en,
   input  wire logic  i_tx_frame_valid,
   input  wire logic  i_tx_data,
   input  wire logic  i_idle_return_zero,
   input  wire logic  i_rx_line,
   input  wire logic  i_col_line,
   output logic       o_tx_bit_clock,
   output logic       o_tx_line,
   output logic       o_tx_drive,
   output mscod_rx_s  o_rx,
   output logic       o_collision_flag
);
   localparam int unsigned IDLE_HOLD_CYC = mscod_min_cyc(IDLE_HOLD_T_NS);
   localparam int unsigned HW = $clog2(IDLE_HOLD_CYC + 1);
   localparam int unsigned CHW = $clog2(COL_HOLD_CYC + 1);
   localparam int ACQ_LIM = int'(ACQ_CYC);

   if (IDLE_HOLD_CYC < 1 || IDLE_HOLD_CYC > 4096) begin : g_bad
      $error("mscod_codec: idle hold time out of range");
   end

   // ---------------- Transmit ----------------
   mscod_tx_e     tx_state;
   mscod_tx_e     next_tx_state;
   logic          tx_bit;
   logic [HW-1:0] hold_cnt;

   // Bit clock low now means this edge is its rising edge
   wire tx_sample = !o_tx_bit_clock;
   wire hold_done = (hold_cnt == '0);

   always_comb begin
      next_tx_state = tx_state;
      if (tx_sample && i_tx_frame_valid) begin
         next_tx_state = TX_SEND;
      end else if (tx_sample && tx_state == TX_SEND) begin
         next_tx_state = i_idle_return_zero ? TX_HOLD : TX_IDLE_HIGH;
      end else if (tx_state == TX_HOLD && hold_done) begin
         next_tx_state = TX_REST;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_tx_bit_clock <= 1'b0;
         tx_state       <= TX_REST;
         tx_bit         <= 1'b0;
         hold_cnt       <= '0;
         o_tx_line      <= 1'b1;
         o_tx_drive     <= 1'b0;
      end else if (i_clk_en) begin
         o_tx_bit_clock <= !o_tx_bit_clock;
         tx_state       <= next_tx_state;
         if (tx_sample) begin
            tx_bit <= i_tx_data;
         end
         if (tx_sample && i_tx_frame_valid) begin
            o_tx_line  <= !i_tx_data;
            o_tx_drive <= 1'b1;
         end else if (!tx_sample && tx_state == TX_SEND) begin
            o_tx_line <= tx_bit;
         end else if (tx_sample && tx_state == TX_SEND) begin
            // End of last cell goes high
            o_tx_line <= 1'b1;
            hold_cnt  <= HW'(IDLE_HOLD_CYC - 1);
         end else if (tx_state == TX_HOLD) begin
            hold_cnt   <= hold_done ? hold_cnt : hold_cnt - HW'(1);
            o_tx_drive <= !hold_done;
         end
      end
   end

   // ---------------- Receive conditioning ----------------
   logic rx_level;
   logic rx_edge;
   logic col_level;
   logic col_edge;

   // One sample per half bit: a half cell may be seen only once,
   // so a transient is rejected only when it misses every sampling edge.
   // Requiring two samples here would swallow every lone half cell.
   // Data path rejects only transients that miss every sampling edge
   mscod_filt #(.STABLE_CYC(RX_FILT_CYC)) u_rx_filt (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_clk_en  (i_clk_en),
      .i_pin     (i_rx_line),
      .o_level   (rx_level),
      .o_edge    (rx_edge)
   );

   mscod_filt #(.STABLE_CYC(COL_FILT_CYC)) u_col_filt (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_clk_en  (i_clk_en),
      .i_pin     (i_col_line),
      .o_level   (col_level),
      .o_edge    (col_edge)
   );

   // ---------------- Decoder ----------------
   logic [1:0] gap;
   logic       last_mid;

   // Edge one half bit after a mid edge is a boundary; any longer gap is mid
   wire is_mid  = !o_rx.carrier || !(last_mid && gap == RX_GAP_HALF);
   wire mid_hit = rx_edge && is_mid;
   wire eop     = o_rx.carrier && !rx_edge && gap == RX_GAP_EOP;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         gap      <= RX_GAP_EOP;
         last_mid <= 1'b0;
         o_rx     <= '0;
      end else if (i_clk_en) begin
         // Phase realigned on every data edge
         gap      <= rx_edge ? RX_GAP_HALF : ((gap == RX_GAP_EOP) ? gap : gap + 2'h1);
         last_mid <= rx_edge ? is_mid : last_mid;
         // Clock out on every mid edge
         o_rx.clk <= mid_hit;
         if (mid_hit) begin
            o_rx.data <= rx_level;
         end
         if (rx_edge) begin
            o_rx.carrier <= 1'b1;
         end else if (eop) begin
            o_rx.carrier <= 1'b0;
         end
      end
   end

   // ---------------- Collision ----------------
   logic [CHW-1:0] col_hold;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         col_hold         <= '0;
         o_collision_flag <= 1'b0;
      end else if (i_clk_en) begin
         // Reload hold on each collision rise
         if (col_edge && col_level) begin
            col_hold <= CHW'(COL_HOLD_CYC);
         end else if (col_hold != '0) begin
            col_hold <= col_hold - CHW'(1);
         end
         o_collision_flag <= col_level || (col_hold != '0) || (col_edge && col_level);
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   AST_BITCLK_DIV: assert property (i_clk_en |=> o_tx_bit_clock != $past(o_tx_bit_clock))
      else $error("bit clock did not toggle");
   AST_TX_FIRST_HALF: assert property ((i_clk_en && tx_sample && i_tx_frame_valid)
      |=> (o_tx_drive && o_tx_line == !$past(i_tx_data)))
      else $error("first half cell wrong");
   AST_TX_MID_EDGE: assert property ((i_clk_en && tx_sample && i_tx_frame_valid) ##1 i_clk_en
      |=> (o_tx_line == $past(i_tx_data, 2) && o_tx_line != $past(o_tx_line)))
      else $error("missing mid cell transition");
   AST_IDLE_HIGH: assert property ((tx_state == TX_IDLE_HIGH) |-> (o_tx_line && o_tx_drive))
      else $error("idle high mode not driving high");
   AST_RZ_RELEASE: assert property ($fell(o_tx_drive) |-> ($past(tx_state) == TX_HOLD && $past(o_tx_line)))
      else $error("drive released outside hold");
   AST_COL_HOLD: assert property ($fell(o_collision_flag)
      |-> ($past(col_hold) == '0 && !$past(col_level)))
      else $error("collision flag dropped early");
   AST_COL_SET: assert property ((i_clk_en && col_edge && col_level) |=> o_collision_flag [*2])
      else $error("collision flag not held");
   AST_EOP_DROP: assert property ($fell(o_rx.carrier) |-> ($past(gap) == RX_GAP_EOP && !$past(rx_edge)))
      else $error("carrier dropped with transitions present");
   AST_RXCLK_LOW: assert property ((!o_rx.carrier && !$past(o_rx.carrier) && !$past(rx_edge)) |-> !o_rx.clk)
      else $error("receive clock active without carrier");
   AST_ACQ: assert property (($rose(o_rx.carrier) && i_clk_en) |-> ##[0:ACQ_LIM] o_rx.clk)
      else $error("no receive clock after carrier");

   COV_TX_FRAME: cover property ((tx_state == TX_SEND) ##1 (tx_state == TX_SEND) [*4] ##1 (tx_state == TX_HOLD));
   COV_IDLE_HIGH: cover property ((tx_state == TX_SEND) ##[1:4] (tx_state == TX_IDLE_HIGH));
   COV_RX_PACKET: cover property ($rose(o_rx.carrier) ##[1:60] $fell(o_rx.carrier));
   COV_COLLISION: cover property ($rose(o_collision_flag) ##[1:20] $fell(o_collision_flag));

endmodule // mscod_codec

`default_nettype wire

//--- mscod_ctrl_model.sv
// Controller model: sends NRZ frames on the bit clock, counts received bits
`default_nettype none
module mscod_ctrl_model import mscod_pkg::*; (
   input  wire logic      i_sys_clk,
   input  wire logic      i_tx_bit_clock,
   input  wire mscod_rx_s i_rx,
   output var logic       o_tx_frame_valid,
   output var logic       o_tx_data,
   output var int         o_rx_count
);
   timeunit 1ns;
   timeprecision 1ns;
   int rx_cnt = 0;
   assign o_rx_count = rx_cnt;
   initial begin
      o_tx_frame_valid = 1'b0;
      o_tx_data = 1'b0;
   end
   always @(posedge i_sys_clk) begin
      if (i_rx.clk && i_rx.carrier) rx_cnt <= rx_cnt + 1;
   end
   task automatic send(input logic [7:0] b);
      @(posedge i_sys_clk iff !i_tx_bit_clock);
      for (int i = 0; i < 8; i++) begin
         #1;
         o_tx_frame_valid = 1'b1;
         o_tx_data = b[i];
         repeat (2) @(posedge i_sys_clk);
      end
      #1 o_tx_frame_valid = 1'b0;
      o_tx_data = 1'b0;
   endtask
endmodule // mscod_ctrl_model
`default_nettype wire

//--- mscod_codec_tb.sv
// Self-checking bench for the Manchester serial codec
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s expected %b seen %b", nm, e, g); end end
module mscod_codec_tb import mscod_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       i_idle_return_zero = 1'b0;
   logic       i_rx_line = 1'b0;
   logic       i_col_line = 1'b0;
   logic       clk_en = 1'b1;
   logic       ctl_valid, ctl_data, o_tx_bit_clock, o_tx_line, o_tx_drive, o_collision_flag, e, frz;
   mscod_rx_s  o_rx;
   int         err_count = 0, n_compared = 0, halves = 0, rx_count;
   logic       tx_q[$], rx_q[$];
   logic [7:0] b;
   always #20 clk = ~clk;
   mscod_codec #(.IDLE_HOLD_T_NS(IDLE_HOLD_NS)) DUT (.i_sys_clk(clk), .i_rst_b(i_rst_b), .i_clk_en(clk_en),
      .i_tx_frame_valid(ctl_valid), .i_tx_data(ctl_data), .i_idle_return_zero(i_idle_return_zero),
      .i_rx_line(i_rx_line), .i_col_line(i_col_line), .o_tx_bit_clock(o_tx_bit_clock),
      .o_tx_line(o_tx_line), .o_tx_drive(o_tx_drive), .o_rx(o_rx), .o_collision_flag(o_collision_flag));
   mscod_ctrl_model ctl (.i_sys_clk(clk), .i_tx_bit_clock(o_tx_bit_clock), .i_rx(o_rx),
      .o_tx_frame_valid(ctl_valid), .o_tx_data(ctl_data), .o_rx_count(rx_count));
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic sel(input int s);
      return (s == 0) ? o_collision_flag : o_rx.carrier;
   endfunction
   task automatic wait_for(input int s, input logic lvl);
      int k;
      for (k = 0; k < 20 && sel(s) !== lvl; k++) tick(1);
      if (k == 20) begin
         $display("mismatch wait_%0d expected %b seen %b", s, lvl, sel(s));
         err_count++;
         stop_test();
      end
   endtask
   // Preamble first so the first edge is a mid cell
   task automatic rx_frame(input logic [15:0] bits);
      for (int i = 0; i < 16; i++) begin
         rx_q.push_back(bits[i]);
         i_rx_line = !bits[i];
         tick(1);
         i_rx_line = bits[i];
         tick(1);
      end
   endtask
   always @(posedge clk) begin
      if (i_rst_b && ctl_valid && !o_tx_bit_clock) halves <= halves + 2;
   end
   always @(negedge clk) begin
      if (halves > 0) begin
         halves--;
         e = tx_q.pop_front();
         `CHK("tx_line", e, o_tx_line)
         `CHK("tx_drive", 1'b1, o_tx_drive)
      end
      if (o_rx.clk === 1'b1) begin
         e = (rx_q.size() > 0) ? rx_q.pop_front() : 1'bx;
         `CHK("rx_data", e, o_rx.data)
      end
   end
   initial begin
      void'($urandom(32'hc82f_fda0));
      tick(8);
      i_rst_b = 1'b1;
      for (int m = 0; m < 2; m++) begin
         i_idle_return_zero = m[0];
         b = 8'($urandom());
         for (int i = 0; i < 8; i++) begin
            tx_q.push_back(!b[i]);
            tx_q.push_back(b[i]);
         end
         ctl.send(b);
         tick(3);
         `CHK("idle_line", 1'b1, o_tx_line)
         `CHK("idle_drive", 1'b1, o_tx_drive)
         // Drive must last a whole hold time after the last cell
         tick(int'(IDLE_HOLD_NS / CLK_PERIOD_NS) - 2);
         `CHK("hold_drive", 1'b1, o_tx_drive)
         tick(1);
         `CHK("idle_after", !m[0], o_tx_drive)
         `CHK("idle_level", 1'b1, o_tx_line)
         $display("tx test mode %0d done", m);
      end
      for (int f = 0; f < 2; f++) begin
         rx_frame({4'h0, 8'($urandom()), 4'h5});
         `CHK("carrier_on", 1'b1, o_rx.carrier)
         wait_for(1, 1'b0);
         tick(4);
         `CHK("rx_left", 0, rx_q.size())
         `CHK("rx_taken", 16 * (f + 1), rx_count)
         $display("rx test frame %0d done", f);
      end
      // Pulses under both thresholds, clear of any sampling edge
      i_rx_line = 1'b1;
      i_col_line = 1'b1;
      #8;
      i_rx_line = 1'b0;
      i_col_line = 1'b0;
      tick(8);
      `CHK("rx_glitch", 1'b0, o_rx.carrier)
      `CHK("col_glitch", 1'b0, o_collision_flag)
      i_col_line = 1'b1;
      tick(2);
      i_col_line = 1'b0;
      wait_for(0, 1'b1);
      // Input already low here: only the hold keeps the flag up
      tick(2);
      `CHK("col_hold", 1'b1, o_collision_flag)
      wait_for(0, 1'b0);
      $display("noise and collision test done");
      clk_en = 1'b0;
      frz = o_tx_bit_clock;
      tick(3);
      `CHK("frozen_bclk", frz, o_tx_bit_clock)
      clk_en = 1'b1;
      tick(1);
      `CHK("resumed_bclk", !frz, o_tx_bit_clock)
      $display("clock enable test done");
      stop_test();
   end
endmodule // mscod_codec_tb
`default_nettype wire
